/* status_mode_pkg.sv */
// constants for the cpu status register three mode bits block
//------------------------------------------------------------
// Behaviour
// - bit 6 rom map select, read/write; 0 keeps on-chip rom mapped in program space
// - rom map select 1 disables on-chip rom and drops it from program map
// - hardware reset loads rom map select from a strap pin
// - software reset instruction leaves rom map select unchanged
// - branch too soon after a select update may still see old select
// - categories: I immediate or fast return, II slow return, III accumulator target
// - bit 5 address-unit saturate resets 0; when 0 overflow wraps
// - address-unit saturate 1 clamps overflow to 7fff or 8000
// - bit 1 multiply saturate; with fractional and data saturate, 18000*18000 gives 7fffffff
// - multiply saturation applies before accumulate or subtract step
// - bit 0 store saturate; legacy mode store saturates 40 to 32 bits after shift
// - sign extend 0: unsigned, above 007fffffff becomes 7fffffff
// - sign extend 1: signed, below minimum 80000000, above maximum 7fffffff
// - legacy mode 0 ignores store saturate; instruction alone decides
// - legacy compat mode is a separate status bit enabling store saturate control
//------------------------------------------------------------
`default_nettype none
package status_mode_pkg;

    //------------------------------------------------------------
    // register layout
    //------------------------------------------------------------
    localparam int          REG_W          = 16;
    localparam int          BIT_ROM_MAP    = 6;
    localparam int          BIT_AU_SAT     = 5;
    localparam int          BIT_MUL_SAT    = 1;
    localparam int          BIT_ST_SAT     = 0;
    localparam logic [3:0]  IDX_ROM_MAP    = 4'h6;
    localparam logic [3:0]  IDX_AU_SAT     = 4'h5;
    localparam logic [3:0]  IDX_MUL_SAT    = 4'h1;
    localparam logic [3:0]  IDX_ST_SAT     = 4'h0;
    localparam logic        RST_AU_SAT     = 1'b0;
    localparam logic        RST_MUL_SAT    = 1'b0;
    localparam logic        RST_ST_SAT     = 1'b0;

    //------------------------------------------------------------
    // fetch-select settle counts, in cycles
    //------------------------------------------------------------
    localparam logic [2:0]  CAT1_BIT_CYC   = 3'h4;
    localparam logic [2:0]  CAT1_MMR_CYC   = 3'h5;
    localparam logic [2:0]  CAT2_BIT_CYC   = 3'h0;
    localparam logic [2:0]  CAT2_MMR_CYC   = 3'h1;

    //------------------------------------------------------------
    // datapath widths and limits
    //------------------------------------------------------------
    localparam int          AU_W           = 16;
    localparam int          MUL_W          = 17;
    localparam int          ACC_W          = 40;
    localparam int          ST_W           = 32;
    localparam logic [15:0] AU_POS_MAX     = 16'h7fff;
    localparam logic [15:0] AU_NEG_MAX     = 16'h8000;
    localparam logic [16:0] MUL_NEG_ONE    = 17'h18000;
    localparam logic [39:0] MUL_SAT_VAL    = 40'h00_7fff_ffff;
    localparam logic [39:0] ST_POS_LIM     = 40'h00_7fff_ffff;
    localparam logic [39:0] ST_NEG_LIM     = 40'hff_8000_0000;
    localparam logic [31:0] ST_POS_SAT     = 32'h7fff_ffff;
    localparam logic [31:0] ST_NEG_SAT     = 32'h8000_0000;

    typedef enum logic [1:0] {
        MAC_NONE = 2'h0,
        MAC_ADD  = 2'h1,
        MAC_SUB  = 2'h2
    } mac_op_t;

endpackage : status_mode_pkg
`default_nettype wire

/* status_mode_bits.sv */
// mode-control bits of cpu status register three and the datapath they steer
`timescale 1ns/1ps
`default_nettype none
module status_mode_bits (
    input  wire logic                               clock_i,
    input  wire logic                               resetn_i,
    input  wire logic                               rom_map_strap_i,
    input  wire logic                               soft_reset_i,
    input  wire logic                               bit_op_valid_i,
    input  wire logic                               bit_op_set_i,
    input  wire logic [3:0]                         bit_op_index_i,
    input  wire logic                               mmr_wr_i,
    input  wire logic [status_mode_pkg::REG_W-1:0]  mmr_wdata_i,
    output logic      [status_mode_pkg::REG_W-1:0]  mmr_rdata_o,
    output logic                                    rom_map_o,
    output logic                                    rom_enable_o,
    output logic                                    rom_map_cat1_o,
    output logic                                    rom_map_cat2_o,
    output logic                                    rom_map_cat3_o,
    output logic                                    addr_unit_saturate_o,
    output logic                                    multiply_saturate_o,
    output logic                                    store_saturate_o,
    input  wire logic                               legacy_compat_mode_i,
    input  wire logic                               sign_extend_mode_i,
    input  wire logic                               fractional_mode_i,
    input  wire logic                               data_unit_saturate_i,
    input  wire logic                               wide_overflow_mode_i,
    input  wire logic [status_mode_pkg::AU_W-1:0]   au_a_i,
    input  wire logic [status_mode_pkg::AU_W-1:0]   au_b_i,
    input  wire logic                               au_sub_i,
    output logic      [status_mode_pkg::AU_W-1:0]   au_result_o,
    input  wire logic [status_mode_pkg::MUL_W-1:0]  mul_a_i,
    input  wire logic [status_mode_pkg::MUL_W-1:0]  mul_b_i,
    input  wire status_mode_pkg::mac_op_t           mac_op_i,
    input  wire logic [status_mode_pkg::ACC_W-1:0]  mac_acc_i,
    output logic      [status_mode_pkg::ACC_W-1:0]  mul_product_o,
    output logic      [status_mode_pkg::ACC_W-1:0]  mac_result_o,
    input  wire logic [status_mode_pkg::ACC_W-1:0]  st_acc_i,
    input  wire logic [5:0]                         st_shift_i,
    input  wire logic                               st_insn_sat_i,
    output logic      [status_mode_pkg::ST_W-1:0]   st_data_o
);
    import status_mode_pkg::*;

    //------------------------------------------------------------
    // strap synchroniser
    //------------------------------------------------------------
    logic strap_q1_ff;
    logic strap_q2_ff;

    always_ff @(posedge clock_i) begin
        strap_q1_ff <= rom_map_strap_i;
        strap_q2_ff <= strap_q1_ff;
    end

    //------------------------------------------------------------
    // mode bit registers
    //------------------------------------------------------------
    logic rom_map_ff;
    logic au_sat_ff;
    logic mul_sat_ff;
    logic st_sat_ff;
    logic nxt_rom_map;
    logic rom_by_bit;
    logic rom_by_mmr;
    logic rom_upd;

    function automatic logic bit_next(input logic cur, input logic [3:0] idx, input logic [REG_W-1:0] wd,
                                      input int pos);
        logic r;
        r = cur;
        if (mmr_wr_i) begin
            r = wd[pos];
        end else if (bit_op_valid_i && (bit_op_index_i == idx)) begin
            r = bit_op_set_i;
        end
        return r;
    endfunction : bit_next

    // a memory-mapped write wins over a bit instruction in the same cycle
    // always_comb, not assign: the function reads write strobes that are not its arguments
    always_comb begin
        nxt_rom_map = bit_next(rom_map_ff, IDX_ROM_MAP, mmr_wdata_i, BIT_ROM_MAP);
    end
    assign rom_by_mmr  = mmr_wr_i && (nxt_rom_map != rom_map_ff);
    assign rom_by_bit  = !mmr_wr_i && (nxt_rom_map != rom_map_ff);
    assign rom_upd     = rom_by_mmr || rom_by_bit;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rom_map_ff <= strap_q2_ff;
        end else begin
            rom_map_ff <= nxt_rom_map;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i || soft_reset_i) begin
            au_sat_ff  <= RST_AU_SAT;
            mul_sat_ff <= RST_MUL_SAT;
            st_sat_ff  <= RST_ST_SAT;
        end else begin
            au_sat_ff  <= bit_next(au_sat_ff, IDX_AU_SAT, mmr_wdata_i, BIT_AU_SAT);
            mul_sat_ff <= bit_next(mul_sat_ff, IDX_MUL_SAT, mmr_wdata_i, BIT_MUL_SAT);
            st_sat_ff  <= bit_next(st_sat_ff, IDX_ST_SAT, mmr_wdata_i, BIT_ST_SAT);
        end
    end

    always_comb begin
        mmr_rdata_o              = '0;
        mmr_rdata_o[BIT_ROM_MAP] = rom_map_ff;
        mmr_rdata_o[BIT_AU_SAT]  = au_sat_ff;
        mmr_rdata_o[BIT_MUL_SAT] = mul_sat_ff;
        mmr_rdata_o[BIT_ST_SAT]  = st_sat_ff;
    end

    assign rom_map_o            = rom_map_ff;
    assign rom_enable_o         = !rom_map_ff;
    assign addr_unit_saturate_o = au_sat_ff;
    assign multiply_saturate_o  = mul_sat_ff;
    assign store_saturate_o     = st_sat_ff;

    //------------------------------------------------------------
    // fetch select as each branch category sees it
    //------------------------------------------------------------
    // the old select lingers in the fetch decode for a while; software must wait it out
    logic [2:0] cat1_cnt_ff;
    logic [2:0] cat2_cnt_ff;
    logic       cat1_hold_ff;
    logic       cat2_hold_ff;

    function automatic logic [2:0] settle_next(input logic [2:0] cnt, input logic [2:0] bit_cyc,
                                               input logic [2:0] mmr_cyc);
        logic [2:0] r;
        r = (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
        if (rom_by_bit) begin
            r = bit_cyc;
        end else if (rom_by_mmr) begin
            r = mmr_cyc;
        end
        return r;
    endfunction : settle_next

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cat1_cnt_ff <= 3'h0;
            cat2_cnt_ff <= 3'h0;
        end else begin
            cat1_cnt_ff <= settle_next(cat1_cnt_ff, CAT1_BIT_CYC, CAT1_MMR_CYC);
            cat2_cnt_ff <= settle_next(cat2_cnt_ff, CAT2_BIT_CYC, CAT2_MMR_CYC);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cat1_hold_ff <= 1'b0;
            cat2_hold_ff <= 1'b0;
        end else begin
            // every change parks the value it replaced, so a quick toggle back still shows a stale view
            if (rom_upd) begin
                cat1_hold_ff <= rom_map_ff;
            end
            if (rom_upd) begin
                cat2_hold_ff <= rom_map_ff;
            end
        end
    end

    assign rom_map_cat1_o = (cat1_cnt_ff != 3'h0) ? cat1_hold_ff : rom_map_ff;
    assign rom_map_cat2_o = (cat2_cnt_ff != 3'h0) ? cat2_hold_ff : rom_map_ff;
    assign rom_map_cat3_o = rom_map_ff;

    //------------------------------------------------------------
    // address-unit alu saturation
    //------------------------------------------------------------
    logic [AU_W-1:0] au_sum;
    logic            au_ovf;

    assign au_sum = au_sub_i ? au_a_i - au_b_i : au_a_i + au_b_i;
    assign au_ovf = au_sub_i ? (au_a_i[AU_W-1] != au_b_i[AU_W-1]) && (au_sum[AU_W-1] != au_a_i[AU_W-1])
                             : (au_a_i[AU_W-1] == au_b_i[AU_W-1]) && (au_sum[AU_W-1] != au_a_i[AU_W-1]);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            au_result_o <= '0;
        end else if (au_sat_ff && au_ovf) begin
            au_result_o <= au_a_i[AU_W-1] ? AU_NEG_MAX : AU_POS_MAX;
        end else begin
            au_result_o <= au_sum;
        end
    end

    //------------------------------------------------------------
    // multiplier saturation ahead of accumulate
    //------------------------------------------------------------
    // wide_overflow_mode_i is deliberately unused by the clamp: the saturated product ignores it
    logic [ACC_W-1:0] prod_raw;
    logic [ACC_W-1:0] nxt_product;
    logic             mul_clamp;

    assign prod_raw    = ACC_W'($signed(mul_a_i) * $signed(mul_b_i));
    assign mul_clamp   = mul_sat_ff && fractional_mode_i && data_unit_saturate_i
                         && (mul_a_i == MUL_NEG_ONE) && (mul_b_i == MUL_NEG_ONE);
    assign nxt_product = mul_clamp ? MUL_SAT_VAL
                       : (fractional_mode_i ? {prod_raw[ACC_W-2:0], 1'b0} : prod_raw);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            mul_product_o <= '0;
            mac_result_o  <= '0;
        end else begin
            mul_product_o <= nxt_product;
            case (mac_op_i)
                MAC_ADD: mac_result_o <= mac_acc_i + nxt_product;
                MAC_SUB: mac_result_o <= mac_acc_i - nxt_product;
                default: mac_result_o <= nxt_product;
            endcase
        end
    end

    //------------------------------------------------------------
    // accumulator store saturation
    //------------------------------------------------------------
    logic [ACC_W-1:0] st_shifted;
    logic             st_sat_on;
    logic [ST_W-1:0]  nxt_st_data;

    assign st_shifted = st_shift_i[5] ? ACC_W'($signed(st_acc_i) >>> (6'h0 - st_shift_i))
                                      : (st_acc_i << st_shift_i);   // shift first
    assign st_sat_on  = legacy_compat_mode_i ? st_sat_ff : st_insn_sat_i;

    always_comb begin
        nxt_st_data = st_shifted[ST_W-1:0];
        if (st_sat_on) begin
            if (!sign_extend_mode_i) begin
                if (st_shifted > ST_POS_LIM) begin
                    nxt_st_data = ST_POS_SAT;
                end
            end else if ($signed(st_shifted) < $signed(ST_NEG_LIM)) begin
                nxt_st_data = ST_NEG_SAT;
            end else if ($signed(st_shifted) > $signed(ST_POS_LIM)) begin
                nxt_st_data = ST_POS_SAT;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            st_data_o <= '0;
        end else begin
            st_data_o <= nxt_st_data;
        end
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_strap_load: assert property ($rose(resetn_i) |-> rom_map_o == $past(strap_q2_ff))
        else $error("rom map select not loaded from strap");
    a_rom_set_map: assert property (bit_op_valid_i && !mmr_wr_i && bit_op_set_i
                                    && bit_op_index_i == IDX_ROM_MAP |=> !rom_enable_o && rom_map_o)
        else $error("rom still enabled after select set");
    a_soft_keep: assert property (soft_reset_i && !bit_op_valid_i && !mmr_wr_i |=> $stable(rom_map_o))
        else $error("soft reset changed rom map select");
    a_cat1_bit_lag: assert property (rom_by_bit ##1 !rom_upd [*4] |-> rom_map_cat1_o != rom_map_o)
        else $error("category one saw new select too early");
    a_cat1_bit_done: assert property (rom_by_bit ##1 !rom_upd [*5] |-> rom_map_cat1_o == rom_map_o)
        else $error("category one select not settled after four cycles");
    a_cat1_mmr_done: assert property (rom_by_mmr ##1 !rom_upd [*5] |-> rom_map_cat1_o != rom_map_o
                                      ##1 rom_map_cat1_o == rom_map_o || rom_upd)
        else $error("category one select wrong after memory write");
    a_cat2_mmr_lag: assert property (rom_by_mmr |=> rom_map_cat2_o != rom_map_o
                                     ##1 rom_map_cat2_o == rom_map_o || rom_upd)
        else $error("category two select wrong after memory write");
    a_cat2_bit_now: assert property (rom_by_bit |=> rom_map_cat2_o == rom_map_o)
        else $error("category two select lagged after bit instruction");
    a_au_clamp: assert property (au_sat_ff && au_ovf && !au_a_i[AU_W-1] |=> au_result_o == AU_POS_MAX)
        else $error("address unit positive overflow not clamped");
    a_au_wrap: assert property (!au_sat_ff && !au_sub_i |=> au_result_o == $past(au_a_i) + $past(au_b_i))
        else $error("address unit result altered with saturation off");
    a_mul_clamp: assert property (mul_sat_ff && fractional_mode_i && data_unit_saturate_i
                                  && mul_a_i == MUL_NEG_ONE && mul_b_i == MUL_NEG_ONE
                                  |=> mul_product_o == MUL_SAT_VAL)
        else $error("negative one squared not saturated");
    a_mac_after_sat: assert property (mac_op_i == MAC_ADD |=> mac_result_o == $past(mac_acc_i) + mul_product_o)
        else $error("accumulate not using saturated product");
    a_store_unsigned: assert property (legacy_compat_mode_i && st_sat_ff && !sign_extend_mode_i
                                       && st_shifted > ST_POS_LIM |=> st_data_o == ST_POS_SAT)
        else $error("unsigned store not saturated");
    a_store_neg: assert property (legacy_compat_mode_i && st_sat_ff && sign_extend_mode_i
                                  && $signed(st_shifted) < $signed(ST_NEG_LIM) |=> st_data_o == ST_NEG_SAT)
        else $error("signed store not saturated low");
    a_store_ignored: assert property (!legacy_compat_mode_i && !st_insn_sat_i
                                      |=> st_data_o == ST_W'($past(st_shifted)))
        else $error("store saturated with legacy mode off");

    c_rom_bit_flip: cover property (rom_by_bit ##1 !rom_upd [*4]);
    c_rom_mmr_flip: cover property (rom_by_mmr ##1 !rom_upd [*5]);
    c_mul_clamp:    cover property (mul_clamp && wide_overflow_mode_i && mac_op_i == MAC_SUB);
    c_store_sat:    cover property (legacy_compat_mode_i && st_sat_ff && sign_extend_mode_i && st_shift_i != 6'h0);

endmodule : status_mode_bits
`default_nettype wire

/* tb_status_mode_bits.sv */
// self-checking bench for the status register mode bits block
`timescale 1ns/1ps
`default_nettype none
module tb_status_mode_bits;
    import status_mode_pkg::*;
    logic        clock_i, resetn_i, strap, srst, bv, bit_set_instruction, mwr, leg, sxm, frc, sdu, wid, asub, ins;
    logic        rmap, ren, c1, c2, c3, aus, mus, sts;
    logic [3:0]  bidx;
    logic [15:0] wd, rd, a, b, aur, r;
    logic [16:0] ma, mb;
    mac_op_t     mop;
    logic [39:0] acc, sacc, prod, macr, ep;
    logic [5:0]  sh;
    logic [31:0] sto;
    int          mismatches, checks, seed;

    status_mode_bits uut (.clock_i(clock_i), .resetn_i(resetn_i), .rom_map_strap_i(strap), .soft_reset_i(srst),
        .bit_op_valid_i(bv), .bit_op_set_i(bit_set_instruction), .bit_op_index_i(bidx), .mmr_wr_i(mwr), .mmr_wdata_i(wd),
        .mmr_rdata_o(rd), .rom_map_o(rmap), .rom_enable_o(ren), .rom_map_cat1_o(c1), .rom_map_cat2_o(c2),
        .rom_map_cat3_o(c3), .addr_unit_saturate_o(aus), .multiply_saturate_o(mus), .store_saturate_o(sts),
        .legacy_compat_mode_i(leg), .sign_extend_mode_i(sxm), .fractional_mode_i(frc), .data_unit_saturate_i(sdu),
        .wide_overflow_mode_i(wid), .au_a_i(a), .au_b_i(b), .au_sub_i(asub), .au_result_o(aur), .mul_a_i(ma),
        .mul_b_i(mb), .mac_op_i(mop), .mac_acc_i(acc), .mul_product_o(prod), .mac_result_o(macr),
        .st_acc_i(sacc), .st_shift_i(sh), .st_insn_sat_i(ins), .st_data_o(sto));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    //------------------------------------------------------------
    // reference model
    //------------------------------------------------------------
    function automatic logic [15:0] m_au(logic [15:0] x, logic [15:0] y, logic s, logic sat);
        int v;
        v = s ? $signed(x) - $signed(y) : $signed(x) + $signed(y);
        if (sat && v > 32767) return 16'h7fff;
        if (sat && v < -32768) return 16'h8000;
        return v[15:0];
    endfunction : m_au

    function automatic logic [39:0] m_mul(logic [16:0] x, logic [16:0] y, logic f, logic clamp);
        longint p;
        if (clamp && f && x == 17'h18000 && y == 17'h18000) return 40'h00_7fff_ffff;
        p = $signed(x) * $signed(y);
        if (f) p = p <<< 1;
        return p[39:0];
    endfunction : m_mul

    // 40-bit shift keeps the low 40 bits, so saturation judges the shifted value
    function automatic logic [31:0] m_st(logic [39:0] v, logic [5:0] s, logic on, logic sx);
        longint t;
        t = $signed(v);
        t = ($signed(s) < 0) ? (t >>> (-$signed(s))) : (t <<< s);
        t = {{24{t[39]}}, t[39:0]};
        if (on && !sx && t[39:0] > 40'h00_7fff_ffff) return 32'h7fff_ffff;
        if (on && sx && t > 64'sh0000_0000_7fff_ffff) return 32'h7fff_ffff;
        if (on && sx && t < 64'shffff_ffff_8000_0000) return 32'h8000_0000;
        return t[31:0];
    endfunction : m_st

    //------------------------------------------------------------
    // drivers and compares
    //------------------------------------------------------------
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_reg();
        chk("status bits", {24'h0, r}, {24'h0, rd});
        chk("rom map", {39'h0, r[6]}, {39'h0, rmap});
        chk("rom enable", {39'h0, !r[6]}, {39'h0, ren});
        chk("sat bits", {37'h0, r[5], r[1], r[0]}, {37'h0, aus, mus, sts});
    endtask : chk_reg

    task automatic do_reset(input logic s);
        resetn_i = 1'b0;
        strap = s;
        repeat (3) @(posedge clock_i);
        #1 resetn_i = 1'b1;
        r = {9'h0, s, 6'h0};
        @(posedge clock_i);
        #1 chk_reg();
    endtask : do_reset

    task automatic bitop(input logic s, input logic [3:0] i);
        @(posedge clock_i);
        #1 bv = 1'b1;
        bit_set_instruction = s;
        bidx = i;
        @(posedge clock_i);
        #1 bv = 1'b0;
        if (i inside {4'h6, 4'h5, 4'h1, 4'h0}) r[i] = s;
    endtask : bitop

    task automatic mmr(input logic [15:0] d);
        @(posedge clock_i);
        #1 mwr = 1'b1;
        wd = d;
        @(posedge clock_i);
        #1 mwr = 1'b0;
        r = d & 16'h0063;
    endtask : mmr

    // o is the select before the change; k is 1 just after the write edge and counts edges from it
    task automatic views(input int n1, input int n2, input logic o);
        for (int k = 1; k < 8; k++) begin
            chk("cat1 view", {39'h0, (k <= n1) ? o : !o}, {39'h0, c1});
            chk("cat2 view", {39'h0, (k <= n2) ? o : !o}, {39'h0, c2});
            chk("cat3 view", {39'h0, !o}, {39'h0, c3});
            @(posedge clock_i);
            #1;
        end
    endtask : views

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    initial begin
        #60000;
        mismatches++;
        finish_test();
    end

    initial begin
        logic [15:0] snap;
        int          q;
        logic [3:0]  idx [6] = '{4'h6, 4'h5, 4'h1, 4'h0, 4'h3, 4'hf};
        seed = 32'h931c2641;
        mismatches = 0;
        checks = 0;
        {strap, srst, bv, bit_set_instruction, mwr, leg, sxm, frc, sdu, wid, asub, ins} = '0;
        {bidx, wd, a, b, ma, mb, acc, sacc, sh} = '0;
        mop = MAC_NONE;
        do_reset(1'b1);
        for (int i = 0; i < 12; i++) begin
            bitop(i < 6, idx[i % 6]);
            chk_reg();
        end
        for (int i = 0; i < 2; i++) begin
            bitop(!r[6], 4'h6);
            views(4, 0, !r[6]);
            mmr((16'($random(seed)) & 16'hffbf) | {9'h0, !r[6], 6'h0});
            chk_reg();
            views(5, 1, !r[6]);
        end
        mmr(16'hffff);
        @(posedge clock_i);
        #1 srst = 1'b1;
        @(posedge clock_i);
        #1 srst = 1'b0;
        r = r & 16'h0040;
        chk_reg();
        do_reset(1'b0);
        for (int i = 0; i < 600; i++) begin
            snap = r;
            {leg, sxm, frc, sdu, wid, asub, ins} = 7'($random(seed));
            a = 16'($random(seed));
            b = 16'($random(seed));
            ma = $random(seed) & 1 ? 17'h18000 : 17'($random(seed));
            mb = $random(seed) & 1 ? 17'h18000 : 17'($random(seed));
            mop = mac_op_t'({$random(seed)} % 3);
            acc = {8'($random(seed)), 32'($random(seed))};
            sacc = {8'($random(seed)), 32'($random(seed))};
            if ($random(seed) & 1) sacc = {{8{sacc[31]}}, sacc[31:0]};
            q = {$random(seed)} % 17 - 8;
            sh = q[5:0];
            mwr = (i % 5 == 0);
            wd = 16'($random(seed));
            @(posedge clock_i);
            #1 chk("au result", {24'h0, m_au(a, b, asub, snap[5])}, {24'h0, aur});
            ep = m_mul(ma, mb, frc, snap[1] && sdu);
            chk("product", ep, prod);
            chk("mac result", mop == MAC_ADD ? acc + ep : mop == MAC_SUB ? acc - ep : ep, macr);
            chk("store", {8'h0, m_st(sacc, sh, leg ? snap[0] : ins, sxm)}, {8'h0, sto});
            if (mwr) r = wd & 16'h0063;
            chk_reg();
        end
        mwr = 1'b0;
        finish_test();
    end
endmodule : tb_status_mode_bits
`default_nettype wire
